//--- rtl/dsp_pin_map.svh
// Contract
// [R1] Outside reset logic holds reset low at least five processor cycles.
// [R2] Clock generator reports lock within 2000 input clock cycles; reset stretched meanwhile.
// [R3] Interrupt and flag inputs sampled against processor clock, recognized this or next cycle.
// [R4] Level interrupt sources hold their line low until serviced.
// [R5] Bus request is asynchronous, recognized this cycle or the following one.
// [R6] Float strobes before grant low; re-drive strobes only after grant high.
// [R7] Assert grant-hung while granted away and execution needs the external bus; the code also asserts it in BUS_FLOATING and BUS_RESUME.
// [R8] Mode pins captured at the rising edge of reset.
// [R9] Flag outputs update after the falling edge of the processor clock.
// [R10] Processor cycle runs at twice the input clock rate.
// [R11] Asynchronous request and interrupt inputs pass a two-stage synchronizer.
`ifndef DSP_PIN_MAP_SVH
`define DSP_PIN_MAP_SVH
`define LOCK_CKI_CYCLES   2000
`define RESET_MIN_CK      5
`define NUM_IRQ           6
`define NUM_PF            8
`define NUM_FL            3
`define NUM_MS            5
`define NUM_MODE          4
`define MODE_RESET_VAL    4'h0
`endif

//--- rtl/dsp_pin_pkg.sv
package dsp_pin_pkg;
  typedef enum logic [1:0] {
    BUS_OWNED    = 2'b00,
    BUS_FLOATING = 2'b01,
    BUS_GRANTED  = 2'b10,
    BUS_RESUME   = 2'b11
  } bus_state_t;

  typedef struct packed {
    logic       sel_n;
    logic       rd_n;
    logic       wr_n;
  } strobe_t;
endpackage : dsp_pin_pkg

//--- rtl/dsp_system_pin_control.sv
`timescale 1ns/1ps
`include "dsp_pin_map.svh"
module dsp_system_pin_control
  import dsp_pin_pkg::*;
#(
  parameter int LOCK_CKI_CYCLES = `LOCK_CKI_CYCLES,
  parameter int NUM_IRQ         = `NUM_IRQ,
  parameter int NUM_PF          = `NUM_PF,
  parameter int NUM_FL          = `NUM_FL,
  parameter int NUM_MS          = `NUM_MS,
  parameter int NUM_MODE        = `NUM_MODE
) (
  // Clock, enable and reset
  input  wire logic                clk_sys,
  input  wire logic                ce,
  input  wire logic                rst,
  input  wire logic                ref_clock_in,
  output logic                     processor_clock_out,
  output logic                     core_reset,
  output logic                     pll_locked,
  // Mode straps
  input  wire logic [NUM_MODE-1:0] mode_pins,
  output logic [NUM_MODE-1:0]      mode_latched,
  // Interrupts and flags
  input  wire logic [NUM_IRQ-1:0]  ext_interrupt_lines,
  input  wire logic                sense_input,
  output logic [NUM_IRQ-1:0]       irq_recognized,
  output logic                     sense_recognized,
  input  wire logic [NUM_PF-1:0]   programmable_io_pins_in,
  output logic [NUM_PF-1:0]        pf_recognized,
  input  wire logic [NUM_PF-1:0]   pf_out_value,
  input  wire logic [NUM_PF-1:0]   pf_out_dir,
  output logic [NUM_PF-1:0]        programmable_io_pins_out,
  output logic [NUM_PF-1:0]        programmable_io_pins_oe,
  input  wire logic [NUM_FL-1:0]   fl_out_value,
  output logic [NUM_FL-1:0]        signal_output_pins,
  // Bus arbitration
  input  wire logic                bus_request_n,
  output logic                     bus_grant_n,
  output logic                     bus_grant_hung_n,
  input  wire logic                core_needs_bus,
  output logic                     core_bus_stall,
  // Memory strobes from the core and to the pins
  input  wire logic [NUM_MS-1:0]   core_ms_n,
  input  wire strobe_t             core_strobe,
  output logic [NUM_MS-1:0]        memory_selects,
  output strobe_t                  strobe_out,
  output logic                     strobe_oe
);

  localparam int LCW = $clog2(LOCK_CKI_CYCLES + 1);
  localparam int RCW = $clog2(`RESET_MIN_CK + 1);

  // Input clock synchroniser and edge detect
  logic       ref_s1;
  logic       ref_s2;
  logic       ref_s3;
  logic       ref_rise;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
    end else if (ce) begin
      ref_s1 <= ref_clock_in;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
    end
  end
  assign ref_rise = ref_s2 & ~ref_s3;

  // Processor cycle timing: rise on every input edge, fall halfway to the next one
  // The half period is measured in system clocks and saturates, so a very slow
  // input clock gives a shortened high phase rather than a missed cycle
  localparam int HCW = 8;
  logic [HCW-1:0] half_cnt;
  logic [HCW-1:0] half_len;
  logic           ref_edge;
  logic           mid_point;
  logic           ck_fall;
  logic           ck_rise;
  assign ref_edge  = ref_s2 ^ ref_s3;
  assign mid_point = ~ref_edge & (half_cnt == (half_len >> 1));
  assign ck_rise   = ref_edge; // [R10]
  assign ck_fall   = mid_point & processor_clock_out;

  // Length of the last input half period in system clocks
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      half_cnt <= '0;
      half_len <= '0;
    end else if (ce) begin
      if (ref_edge) begin
        half_len <= half_cnt;
        half_cnt <= '0;
      end else if (half_cnt != '1) begin
        half_cnt <= half_cnt + 1'b1;
      end
    end
  end

  // Processor clock: two full cycles per input period
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      processor_clock_out <= 1'b0;
    end else if (ce) begin
      if (ck_rise) begin
        processor_clock_out <= 1'b1; // [R10]
      end else if (ck_fall) begin
        processor_clock_out <= 1'b0;
      end
    end
  end

  // Lock counter on input clock rises; holds the core in reset until done
  logic [LCW-1:0] lock_cnt;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lock_cnt   <= '0;
      pll_locked <= 1'b0;
    end else if (ce && ref_rise && !pll_locked) begin
      if (lock_cnt == LCW'(LOCK_CKI_CYCLES - 1)) begin
        pll_locked <= 1'b1; // [R2]
      end
      lock_cnt <= lock_cnt + 1'b1;
    end
  end

  // Extra processor cycles of core reset after lock
  logic [RCW-1:0] rst_cnt;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rst_cnt    <= '0;
      core_reset <= 1'b1;
    end else if (ce && pll_locked && core_reset && ck_rise) begin
      if (rst_cnt == RCW'(`RESET_MIN_CK - 1)) begin
        core_reset <= 1'b0; // [R1] [R2]
      end
      rst_cnt <= rst_cnt + 1'b1;
    end
  end

  // Mode straps caught once at the first edge after reset release
  logic mode_taken;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_taken   <= 1'b0;
      mode_latched <= NUM_MODE'(`MODE_RESET_VAL);
    end else if (ce && !mode_taken) begin
      mode_taken   <= 1'b1;
      mode_latched <= mode_pins; // [R8]
    end
  end

  // Two-stage synchronisers for asynchronous inputs
  localparam int SW = NUM_IRQ + 1 + NUM_PF + 1;
  logic [SW-1:0] async_in;
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  assign async_in = {bus_request_n, programmable_io_pins_in, sense_input, ext_interrupt_lines};
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1 <= '1;
      sync2 <= '1;
    end else if (ce) begin
      sync1 <= async_in; // [R11]
      sync2 <= sync1;
    end
  end

  // Recognise interrupts and flags once per processor cycle, at its falling edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_recognized   <= '0;
      sense_recognized <= 1'b0;
      pf_recognized    <= '0;
    end else if (ce && ck_fall) begin
      irq_recognized   <= ~sync2[NUM_IRQ-1:0]; // [R3] [R4]
      sense_recognized <= sync2[NUM_IRQ]; // [R3]
      pf_recognized    <= sync2[NUM_IRQ+NUM_PF:NUM_IRQ+1];
    end
  end

  // Flag outputs change only after the processor clock falls
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      programmable_io_pins_out <= '0;
      programmable_io_pins_oe  <= '0;
      signal_output_pins       <= '0;
    end else if (ce && ck_fall) begin
      programmable_io_pins_out <= pf_out_value; // [R9]
      programmable_io_pins_oe  <= pf_out_dir;
      signal_output_pins       <= fl_out_value; // [R9]
    end
  end

  // Bus request / grant sequencing
  bus_state_t state;
  logic       req;
  assign req = ~sync2[SW-1]; // [R5]
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= BUS_OWNED;
    end else if (ce && ck_rise) begin
      unique case (state)
        BUS_OWNED: begin
          if (req && !core_reset) begin
            state <= BUS_FLOATING; // [R5]
          end
        end
        BUS_FLOATING: begin
          state <= BUS_GRANTED; // [R6]
        end
        BUS_GRANTED: begin
          if (!req) begin
            state <= BUS_RESUME;
          end
        end
        BUS_RESUME: begin
          state <= BUS_OWNED; // [R6]
        end
      endcase
    end
  end

  // Grant low only once strobes float; strobes return one cycle after grant high
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_grant_n      <= 1'b1;
      strobe_oe        <= 1'b1;
      bus_grant_hung_n <= 1'b1;
    end else if (ce) begin
      bus_grant_n      <= ~(state == BUS_GRANTED); // [R6]
      strobe_oe        <= (state == BUS_OWNED); // [R6]
      bus_grant_hung_n <= ~((state != BUS_OWNED) && core_needs_bus); // [R7]
    end
  end

  assign core_bus_stall = (state != BUS_OWNED) & core_needs_bus;

  // Strobe data registered; parked high while floated
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      memory_selects <= '1;
      strobe_out     <= '1;
    end else if (ce) begin
      memory_selects <= (state == BUS_OWNED) ? core_ms_n : '1;
      strobe_out     <= (state == BUS_OWNED) ? core_strobe : '1;
    end
  end

endmodule : dsp_system_pin_control

//--- verif/dsp_pin_props.sv
`timescale 1ns/1ps
module dsp_pin_props #(
  parameter int NUM_MODE = 4,
  parameter int NUM_FL   = 3
) (
  // Clock, reset and status
  input wire logic                clk_sys,
  input wire logic                rst,
  input wire logic                processor_clock_out,
  input wire logic                core_reset,
  input wire logic                pll_locked,
  input wire logic [NUM_MODE-1:0] mode_pins,
  input wire logic [NUM_MODE-1:0] mode_latched,
  input wire logic [NUM_FL-1:0]   signal_output_pins,
  // Arbitration
  input wire logic                bus_request_n,
  input wire logic                bus_grant_n,
  input wire logic                bus_grant_hung_n,
  input wire logic                core_needs_bus,
  input wire logic                core_bus_stall,
  input wire logic                strobe_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Reset stretched past lock
  sequence s_held;
    core_reset [*5];
  endsequence
  AST_LOCK_FIRST: assert property (!pll_locked |-> core_reset)
    else $error("core left reset before lock");
  AST_STRETCH: assert property ($rose(pll_locked) |-> s_held)
    else $error("reset not stretched after lock");
  AST_MODE_CAPTURE: assert property ($past(rst) |=> mode_latched == $past(mode_pins))
    else $error("mode pins not captured at reset release");
  AST_FLAG_AT_FALL: assert property ($changed(signal_output_pins) |-> !processor_clock_out)
    else $error("flag output moved while processor clock high");
  AST_FLOAT_FIRST: assert property ($fell(bus_grant_n) |-> !strobe_oe)
    else $error("grant given with strobes driven");
  AST_REDRIVE_LATE: assert property ($rose(strobe_oe) |-> bus_grant_n && $past(bus_grant_n, 2))
    else $error("strobes driven before grant returned");
  AST_HUNG: assert property (core_needs_bus && !bus_grant_n |=> !bus_grant_hung_n)
    else $error("grant hung not shown");
  AST_STALL: assert property (core_needs_bus && !bus_grant_n |-> core_bus_stall)
    else $error("core not stalled while bus away");
  AST_GRANT_CAUSE: assert property ($fell(bus_grant_n) |-> !bus_request_n && !core_reset)
    else $error("grant without request");
endmodule : dsp_pin_props
bind dsp_system_pin_control dsp_pin_props #(.NUM_MODE(NUM_MODE), .NUM_FL(NUM_FL)) i_props (.*);

//--- verif/bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model (
  // Clock, reset and command
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic want,
  input wire logic bus_grant_n,
  // Pins towards the device
  output logic     ref_clock_in,
  output logic     bus_request_n
);
  logic [2:0] div;
  // Input clock at a tenth of the system rate, idle low in reset
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div          <= 3'h0;
      ref_clock_in <= 1'b0;
    end else begin
      div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
      if (div == 3'h4) ref_clock_in <= ~ref_clock_in;
    end
  end
  // Request held until grant seen, then dropped on command
  always @(posedge clk_sys or posedge rst) begin
    if (rst) bus_request_n <= 1'b1;
    else if (want) bus_request_n <= 1'b0;
    else if (!bus_grant_n) bus_request_n <= 1'b1;
  end
endmodule : bus_master_model

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import dsp_pin_pkg::*;
  logic clk_sys = 0, ce = 1, rst = 1, want = 0, sense_input = 0, core_needs_bus = 0;
  logic ref_clock_in, processor_clock_out, core_reset, pll_locked, sense_recognized;
  logic bus_request_n, bus_grant_n, bus_grant_hung_n, core_bus_stall, strobe_oe;
  logic [3:0] mode_pins = 4'hA, mode_latched;
  logic [5:0] ext_interrupt_lines = 6'h3F, irq_recognized;
  logic [7:0] programmable_io_pins_in = 0, pf_out_value = 0, pf_out_dir = 0;
  logic [7:0] pf_recognized, programmable_io_pins_out, programmable_io_pins_oe;
  logic [2:0] fl_out_value = 0, signal_output_pins;
  logic [4:0] core_ms_n = 5'h1F, memory_selects;
  strobe_t    core_strobe = 3'h7, strobe_out;
  int         n_mismatch = 0, checks_done = 0;
  dsp_system_pin_control #(.LOCK_CKI_CYCLES(4)) i_dsp_system_pin_control (.*);
  bus_master_model i_bus_master_model (.*);
  always #20 clk_sys = ~clk_sys;
  // Compare and count
  task chk(input string nm, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // Reset values, strap capture, lock and stretch
  task t_reset;
    int n_held;
    n_held = 0;
    repeat (2) @(posedge clk_sys);
    chk("grant", bus_grant_n, 1);
    chk("oe", strobe_oe, 1);
    chk("mode", mode_latched, 4'hA);
    chk("core_reset", core_reset, 1);
    // Count system clocks of reset held after lock
    repeat (400) if (core_reset !== 1'b0) begin
      @(posedge clk_sys);
      if (pll_locked === 1'b1 && core_reset === 1'b1) n_held++;
    end
    chk("locked", pll_locked, 1);
    chk("core_reset", core_reset, 0);
    // Five processor cycles of five system clocks each
    chk("stretch", n_held, 25);
    $display("test reset done");
  endtask : t_reset
  // Processor clock rate against the input clock, and freeze by clock enable
  task t_clock;
    int   n_ck;
    int   n_ref;
    logic last_ck;
    logic last_ref;
    n_ck = 0;
    n_ref = 0;
    last_ck = processor_clock_out;
    last_ref = ref_clock_in;
    // Four input periods of ten system clocks
    repeat (40) begin
      @(posedge clk_sys);
      if (processor_clock_out === 1'b1 && last_ck === 1'b0) n_ck++;
      if (ref_clock_in === 1'b1 && last_ref === 1'b0) n_ref++;
      last_ck = processor_clock_out;
      last_ref = ref_clock_in;
    end
    chk("ref_rises", n_ref, 4);
    chk("ck_rises", n_ck, 8);
    ce <= 1'b0;
    repeat (2) @(posedge clk_sys);
    last_ck = processor_clock_out;
    n_ck = 0;
    repeat (20) begin
      @(posedge clk_sys);
      if (processor_clock_out !== last_ck) n_ck++;
    end
    chk("ck_frozen", n_ck, 0);
    ce <= 1'b1;
    $display("test clock done");
  endtask : t_clock
  // Interrupt, flag and output pin paths
  task t_flags;
    @(posedge clk_sys);
    ext_interrupt_lines <= 6'h2A;
    sense_input <= 1;
    programmable_io_pins_in <= 8'h5C;
    fl_out_value <= 3'h5;
    pf_out_value <= 8'hC3;
    pf_out_dir <= 8'h0F;
    repeat (40) @(posedge clk_sys);
    chk("irq", irq_recognized, 6'h15);
    chk("sense", sense_recognized, 1);
    chk("pf_in", pf_recognized, 8'h5C);
    chk("fl", signal_output_pins, 3'h5);
    chk("pf_out", programmable_io_pins_out, 8'hC3);
    chk("pf_oe", programmable_io_pins_oe, 8'h0F);
    $display("test flags done");
  endtask : t_flags
  // Request, grant, hang and return of the bus
  task t_bus;
    @(posedge clk_sys);
    core_ms_n <= 5'h1A;
    core_strobe <= 3'h2;
    repeat (10) @(posedge clk_sys);
    chk("ms", memory_selects, 5'h1A);
    chk("strobe", strobe_out, 3'h2);
    want <= 1;
    repeat (200) if (bus_grant_n !== 1'b0) @(posedge clk_sys);
    chk("grant", bus_grant_n, 0);
    chk("oe", strobe_oe, 0);
    chk("ms", memory_selects, 5'h1F);
    chk("strobe", strobe_out, 3'h7);
    want <= 0;
    core_needs_bus <= 1;
    repeat (2) @(posedge clk_sys);
    chk("hung", bus_grant_hung_n, 0);
    chk("stall", core_bus_stall, 1);
    repeat (200) if (bus_grant_n !== 1'b1) @(posedge clk_sys);
    chk("oe", strobe_oe, 0);
    repeat (200) if (strobe_oe !== 1'b1) @(posedge clk_sys);
    core_needs_bus <= 0;
    repeat (2) @(posedge clk_sys);
    chk("ms", memory_selects, 5'h1A);
    chk("hung", bus_grant_hung_n, 1);
    chk("stall", core_bus_stall, 0);
    $display("test bus done");
  endtask : t_bus
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    t_reset();
    t_clock();
    t_flags();
    t_bus();
    conclude();
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    conclude();
  end
endmodule : testbench
